// ===== rtl/scd_pkg.sv
// Shared constants and carrier types for the synchronous clock distribution.
// Assumes a single reference clock; every produced clock is a one-cycle
// enable pulse on that clock rather than a separate clock net.
package scd_pkg;

  localparam int unsigned PSC_W      = 8;
  localparam int unsigned SEL_W      = 3;
  localparam logic [7:0]  PSC_TOP    = 8'hff;
  localparam logic [7:0]  PSC_ONE    = 8'h01;
  localparam logic [7:0]  PSC_RST    = 8'h00;
  localparam logic [2:0]  SEL_MAX    = 3'h7;
  localparam logic [2:0]  SEL_RST    = 3'h0;
  localparam logic [3:0]  SEL_SUM_MAX = 4'h7;

  // Division settings: CPU rate is main rate / 2**cpu_sel, APB rate is CPU rate / 2**apb_sel, but never below main rate / 128
  typedef struct packed {
    logic [2:0] cpu_sel;
    logic [2:0] apb_sel;
  } scd_div_cfg_t;

  // Root clock enables, one pulse per produced clock period
  typedef struct packed {
    logic main_tick;
    logic cpu_tick;
    logic ahb_root_tick;
    logic apb_root_tick;
  } scd_root_ticks_t;

  localparam scd_div_cfg_t    CFG_RST   = '{cpu_sel: SEL_RST,
                                            apb_sel: SEL_RST};
  localparam scd_root_ticks_t TICKS_RST = '{default: 1'b0};

endpackage : scd_pkg

// ===== rtl/scd_clock_dist.sv
// Synchronous clock distribution of the power manager: main clock from the
// generic clock pin, shared prescaler, CPU/AHB/APB roots and per-module gates.
// Assumes gate masks, settings and requests come from logic on ref_clk; the
// generic clock input is asynchronous and is sampled as a pin.
//
// Overview of operation
// [R01] The manager bus clock can be turned off; only reset turns it back on.
// [R02] The main clock exists only while the generic clock input toggles.
// [R03] One shared 8-bit prescaler on the main clock feeds CPU, AHB and APB.
// [R04] The CPU clock feeds only the processor; stopping it stops execution.
// [R05] The AHB root clock runs in phase with and at the rate of the CPU clock.
// [R06] The AHB root clock keeps running while the CPU clock is stopped.
// [R07] Each peripheral's AHB clock has its own gate behind the AHB root clock.
// [R08] The APB root clock is in step with the CPU clock and may be divided.
// [R09] The APB root clock keeps running while the CPU clock is stopped.
// [R10] Each APB module's clock has its own gate behind the APB root clock.
// [R11] The interrupt request goes to the interrupt controller, set up first.
// [R12] A debugger halt leaves the manager and its clocks unchanged.
// [R13] In debug mode sleep does not stop any produced clock.
// [R14] New division settings load only at a prescaler wrap, free of glitches.
`timescale 1ns/10ps

module scd_clock_dist #(
  parameter int unsigned AHB_N = 4,
  parameter int unsigned APB_N = 8
) (
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  input  wire logic                     ce,
  input  wire logic                     main_generic_clock_in,
  input  wire scd_pkg::scd_div_cfg_t    div_cfg,
  input  wire logic                     cpu_stop_req,
  input  wire logic                     sleep_req,
  input  wire logic                     debug_mode,
  input  wire logic                     debug_halt,
  input  wire logic                     manager_bus_clock_en,
  input  wire logic [AHB_N-1:0]         ahb_mask,
  input  wire logic [APB_N-1:0]         apb_mask,
  input  wire logic                     power_manager_event,
  output scd_pkg::scd_root_ticks_t      ticks_r,
  output logic [AHB_N-1:0]              ahb_tick_r,
  output logic [APB_N-1:0]              apb_tick_r,
  output logic                          manager_bus_clock_r,
  output logic                          manager_bus_on_r,
  output logic                          power_manager_irq_r
);
  import scd_pkg::*;

  function automatic logic [7:0] sel_mask(input logic [2:0] sel);
    sel_mask = 8'((9'h001 << sel) - 9'h001);
  endfunction : sel_mask

  // Saturating sum: APB divides the CPU rate further, capped at SEL_MAX (7)
  function automatic logic [2:0] sel_add(input logic [2:0] a,
                                         input logic [2:0] b);
    logic [3:0] s;
    s = {1'b0, a} + {1'b0, b};
    sel_add = (s > SEL_SUM_MAX) ? SEL_MAX : s[2:0];
  endfunction : sel_add

  logic                  pin_s1_r;
  logic                  pin_s2_r;
  logic                  pin_s3_r;
  logic                  main_lvl_r;
  logic [PSC_W-1:0]      psc_cnt_r;
  logic [PSC_W-1:0]      psc_cnt_nxt;
  scd_div_cfg_t          cfg_r;
  scd_root_ticks_t       ticks_nxt;
  logic                  mgr_en_nxt;

  wire logic             pin_agree_w;
  wire logic             main_rise_w;
  wire logic             boundary_w;
  wire logic [2:0]       apb_total_w;
  wire logic [7:0]       cpu_mask_w;
  wire logic [7:0]       apb_mask_w;
  wire logic             root_hit_w;
  wire logic             apb_hit_w;
  wire logic             sleep_stop_w;
  wire logic             cpu_gate_w;

  // Only the second and third stages are looked at
  assign pin_agree_w  = (pin_s2_r == pin_s3_r);
  assign main_rise_w  = pin_agree_w & pin_s3_r & ~main_lvl_r;     // [R02]
  assign psc_cnt_nxt  = psc_cnt_r + PSC_ONE;                      // [R03]
  // At the wrap every divided clock sits at a common edge
  assign boundary_w   = main_rise_w & (psc_cnt_r == PSC_TOP);     // [R14]
  assign apb_total_w  = sel_add(cfg_r.cpu_sel, cfg_r.apb_sel);    // [R08]
  assign cpu_mask_w   = sel_mask(cfg_r.cpu_sel);
  assign apb_mask_w   = sel_mask(apb_total_w);
  assign root_hit_w   = main_rise_w
                        & ((psc_cnt_r & cpu_mask_w) == cpu_mask_w); // [R03]
  assign apb_hit_w    = main_rise_w
                        & ((psc_cnt_r & apb_mask_w) == apb_mask_w); // [R08]
  // Sleep is ignored under debug so the debugger can reach everything
  assign sleep_stop_w = sleep_req & ~debug_mode;                  // [R13]
  // A debugger halt is deliberately not an input to the CPU gate
  assign cpu_gate_w   = ~cpu_stop_req & ~sleep_stop_w;            // [R04][R12]

  always_comb begin
    ticks_nxt.main_tick     = main_rise_w;                        // [R02]
    ticks_nxt.cpu_tick      = root_hit_w & cpu_gate_w;            // [R04]
    ticks_nxt.ahb_root_tick = root_hit_w;                         // [R05] [R06]
    ticks_nxt.apb_root_tick = apb_hit_w;                          // [R09]
  end

  // Off is one-way: a later enable request is ignored until reset
  assign mgr_en_nxt = manager_bus_on_r & manager_bus_clock_en;    // [R01]

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_s1_r   <= 1'b0;
      pin_s2_r   <= 1'b0;
      pin_s3_r   <= 1'b0;
      main_lvl_r <= 1'b0;
    end else if (ce) begin
      pin_s1_r   <= main_generic_clock_in;
      pin_s2_r   <= pin_s1_r;
      pin_s3_r   <= pin_s2_r;
      if (pin_agree_w) begin
        main_lvl_r <= pin_s3_r;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      psc_cnt_r <= PSC_RST;
      cfg_r     <= CFG_RST;
    end else if (ce) begin
      if (main_rise_w) begin
        psc_cnt_r <= psc_cnt_nxt;                                 // [R03]
      end
      if (boundary_w) begin
        cfg_r <= div_cfg;                                         // [R14]
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ticks_r    <= TICKS_RST;
      ahb_tick_r <= '0;
      apb_tick_r <= '0;
    end else if (ce) begin
      ticks_r    <= ticks_nxt;
      ahb_tick_r <= {AHB_N{root_hit_w}} & ahb_mask;               // [R07]
      apb_tick_r <= {APB_N{apb_hit_w}} & apb_mask;                // [R10]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      manager_bus_on_r    <= 1'b1;
      manager_bus_clock_r <= 1'b0;
      power_manager_irq_r <= 1'b0;
    end else if (ce) begin
      manager_bus_on_r    <= mgr_en_nxt;                          // [R01]
      manager_bus_clock_r <= apb_hit_w & mgr_en_nxt;              // [R01]
      // Raw request; enabling and priority belong to the controller
      power_manager_irq_r <= power_manager_event;                 // [R11]
    end
  end

  // Checks

  sequence s_bus_clock_off;
    ce && !manager_bus_on_r;
  endsequence

  sequence s_cfg_hold;
    ce && !boundary_w;
  endsequence

  sequence s_frozen;
    !ce;
  endsequence

  sequence s_pin_settled_high;
    ce && pin_s2_r && pin_s3_r && !main_lvl_r;
  endsequence

  AST_MGR_STAYS_OFF: assert property (                            // [R01]
    @(posedge ref_clk) disable iff (rst)
    s_bus_clock_off |=> !manager_bus_on_r && !manager_bus_clock_r)
    else $error("manager bus clock came back without reset");

  AST_NO_MAIN_NO_CLOCK: assert property (                         // [R02]
    @(posedge ref_clk) disable iff (rst)
    (ce && !main_rise_w) |=> !ticks_r.ahb_root_tick
                             && !ticks_r.apb_root_tick
                             && !ticks_r.cpu_tick)
    else $error("clock produced without a main clock edge");

  AST_PSC_STEP: assert property (                                 // [R03]
    @(posedge ref_clk) disable iff (rst)
    (ce && main_rise_w) |=> psc_cnt_r == 8'($past(psc_cnt_r) + 8'h01))
    else $error("prescaler did not advance on a main clock edge");

  AST_CPU_STOPPED: assert property (                              // [R04]
    @(posedge ref_clk) disable iff (rst)
    (ce && cpu_stop_req) |=> !ticks_r.cpu_tick)
    else $error("cpu clock ran while stopped");

  AST_AHB_WITH_CPU: assert property (                             // [R05]
    @(posedge ref_clk) disable iff (rst)
    ticks_r.cpu_tick |-> ticks_r.ahb_root_tick)
    else $error("cpu clock edge without matching ahb root edge");

  AST_AHB_RUNS: assert property (                                 // [R06]
    @(posedge ref_clk) disable iff (rst)
    (ce && root_hit_w && cpu_stop_req) |=> ticks_r.ahb_root_tick)
    else $error("ahb root clock stopped with the cpu clock");

  AST_AHB_GATES: assert property (                                // [R07]
    @(posedge ref_clk) disable iff (rst)
    (ce && !root_hit_w) |=> ahb_tick_r == '0)
    else $error("peripheral ahb clock without a root edge");

  AST_APB_DIVIDED: assert property (                              // [R08]
    @(posedge ref_clk) disable iff (rst)
    ticks_r.apb_root_tick |-> ticks_r.ahb_root_tick)
    else $error("apb root edge not aligned to a cpu rate edge");

  AST_APB_RUNS: assert property (                                 // [R09]
    @(posedge ref_clk) disable iff (rst)
    (ce && apb_hit_w && cpu_stop_req) |=> ticks_r.apb_root_tick)
    else $error("apb root clock stopped with the cpu clock");

  AST_APB_GATES: assert property (                                // [R10]
    @(posedge ref_clk) disable iff (rst)
    (ce && apb_hit_w) |=> apb_tick_r == $past(apb_mask))
    else $error("apb module gate does not follow its mask");

  AST_IRQ_ROUTED: assert property (                               // [R11]
    @(posedge ref_clk) disable iff (rst)
    (ce && power_manager_event) |=> power_manager_irq_r)
    else $error("interrupt request not passed on");

  AST_DEBUG_HALT: assert property (                               // [R12]
    @(posedge ref_clk) disable iff (rst)
    (ce && debug_halt && root_hit_w && !cpu_stop_req && !sleep_req)
      |=> ticks_r.cpu_tick)
    else $error("debug halt altered the cpu clock");

  AST_DEBUG_SLEEP: assert property (                              // [R13]
    @(posedge ref_clk) disable iff (rst)
    (ce && debug_mode && sleep_req && !cpu_stop_req && root_hit_w)
      |=> ticks_r.cpu_tick && ticks_r.ahb_root_tick)
    else $error("sleep stopped a clock in debug mode");

  AST_CFG_AT_WRAP: assert property (                              // [R14]
    @(posedge ref_clk) disable iff (rst)
    s_cfg_hold |=> $stable(cfg_r))
    else $error("division setting changed away from the wrap");

  // Low enable must hold the prescaler, settings, root ticks, bus-on flag and last pin stage
  AST_CE_FREEZE: assert property (                                // [R03]
    @(posedge ref_clk) disable iff (rst)
    s_frozen |=> $stable(psc_cnt_r) && $stable(cfg_r)
                 && $stable(ticks_r) && $stable(manager_bus_on_r)
                 && $stable(pin_s3_r))
    else $error("state moved while the clock enable was low");

  AST_MAIN_FROM_PIN: assert property (                            // [R02]
    @(posedge ref_clk) disable iff (rst)
    s_pin_settled_high |=> ticks_r.main_tick)
    else $error("settled pin rise gave no main clock edge");

  AST_PSC_HOLD: assert property (                                 // [R03]
    @(posedge ref_clk) disable iff (rst)
    (ce && !main_rise_w) |=> $stable(psc_cnt_r))
    else $error("prescaler moved without a main clock edge");

  AST_CPU_NEEDS_ROOT: assert property (                           // [R04]
    @(posedge ref_clk) disable iff (rst)
    (ce && !root_hit_w) |=> !ticks_r.cpu_tick)
    else $error("cpu clock edge off the prescaler boundary");

  AST_CPU_SLEEPS: assert property (                               // [R13]
    @(posedge ref_clk) disable iff (rst)
    (ce && sleep_req && !debug_mode) |=> !ticks_r.cpu_tick)
    else $error("cpu clock ran in sleep outside debug mode");

  AST_AHB_GATE_OPEN: assert property (                            // [R07]
    @(posedge ref_clk) disable iff (rst)
    (ce && root_hit_w) |=> ahb_tick_r == $past(ahb_mask))
    else $error("peripheral ahb gate does not follow its mask");

  AST_APB_NEEDS_ROOT: assert property (                           // [R10]
    @(posedge ref_clk) disable iff (rst)
    (ce && !apb_hit_w) |=> apb_tick_r == '0)
    else $error("module apb clock without a root edge");

  AST_CFG_LOADED: assert property (                               // [R14]
    @(posedge ref_clk) disable iff (rst)
    (ce && boundary_w) |=> cfg_r == $past(div_cfg))
    else $error("division setting not taken at the wrap");

  AST_BUS_CLOCK_ON: assert property (                             // [R01]
    @(posedge ref_clk) disable iff (rst)
    (ce && apb_hit_w && manager_bus_on_r && manager_bus_clock_en)
      |=> manager_bus_clock_r)
    else $error("manager bus clock missing while enabled");

  AST_IRQ_CLEARS: assert property (                               // [R11]
    @(posedge ref_clk) disable iff (rst)
    (ce && !power_manager_event) |=> !power_manager_irq_r)
    else $error("interrupt request held without an event");

endmodule : scd_clock_dist

// ===== test/scd_gclk_model.sv
// Generic clock source model that feeds the main clock pin.
// Assumes ref_clk comes from the bench; the pin moves on its falling edge.
`timescale 1ns/10ps
module scd_gclk_model #(
  parameter int HALF = 3
) (
  input  wire logic ref_clk,
  input  wire logic run,
  output logic      gclk
);
  int cnt = 0;
  initial gclk = 1'b0;
  // Stands low while stopped, as a gated source would
  always @(negedge ref_clk) begin
    if (!run) begin
      gclk <= 1'b0;
      cnt  <= 0;
    end else if (cnt == HALF - 1) begin
      gclk <= ~gclk;
      cnt  <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : scd_gclk_model

// ===== test/scd_clock_dist_test.sv
// Self-checking bench for the clock distribution block.
// Assumes the generic clock model of scd_gclk_model.sv.
`timescale 1ns/10ps
module scd_clock_dist_test;
  import scd_pkg::*;
  logic            ref_clk = 1'b0;
  logic            rst = 1'b1;
  logic            run = 1'b0;
  logic            gclk;
  scd_div_cfg_t    div_cfg = CFG_RST;
  logic            stop_r = 1'b0, sleep = 1'b0, dbg = 1'b0, halt = 1'b0;
  logic            bus_en = 1'b1, ev = 1'b0, ce = 1'b1;
  logic [3:0]      ahb_mask = 4'h0;
  logic [7:0]      apb_mask = 8'h00;
  scd_root_ticks_t ticks, e_ticks;
  logic [3:0]      ahb_tick, e_ahb;
  logic [7:0]      apb_tick, e_apb;
  logic            mbc, on, irq, e_mbc, e_on, e_irq, rise, lvl;
  logic [5:0]      hist;
  logic [31:0]     x = 32'h0000004d;
  logic [31:0]     s;
  scd_div_cfg_t    cfg;
  int              cnt, cs, as, croot, aroot, cycles = 0;
  int              failures = 0;
  int              total_checks = 0;

  always #20 ref_clk = ~ref_clk;

  scd_gclk_model gen_u (.ref_clk(ref_clk), .run(run), .gclk(gclk));

  scd_clock_dist #(.AHB_N(4), .APB_N(8)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .ce(ce),
    .main_generic_clock_in(gclk), .div_cfg(div_cfg),
    .cpu_stop_req(stop_r), .sleep_req(sleep), .debug_mode(dbg),
    .debug_halt(halt), .manager_bus_clock_en(bus_en),
    .ahb_mask(ahb_mask), .apb_mask(apb_mask), .power_manager_event(ev),
    .ticks_r(ticks), .ahb_tick_r(ahb_tick), .apb_tick_r(apb_tick),
    .manager_bus_clock_r(mbc), .manager_bus_on_r(on),
    .power_manager_irq_r(irq));

  function automatic logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : rnd

  // Reference model: three pin stages, a settled level, output registers;
  // everything stands still while the clock enable is low
  always @(posedge ref_clk) begin
    if (rst) begin
      cnt = 0;
      cfg = CFG_RST;
      e_ticks = TICKS_RST;
      {e_ahb, e_apb, e_mbc, e_irq, hist, lvl} = '0;
      e_on = 1'b1;
    end else if (ce) begin
      hist = {hist[4:0], gclk};
      // A pin level counts once the second and third stages agree
      rise = hist[2] == hist[3] && hist[3] && !lvl;
      if (hist[2] == hist[3]) lvl = hist[3];
      cs = int'(cfg.cpu_sel);
      as = cs + int'(cfg.apb_sel);
      if (as > 7) as = 7;
      croot = int'(rise && (cnt % (1 << cs)) == (1 << cs) - 1);
      aroot = int'(rise && (cnt % (1 << as)) == (1 << as) - 1);
      if (rise) begin
        if (cnt == 255) cfg = div_cfg;
        cnt = (cnt + 1) % 256;
      end
      e_ticks = '{rise, croot != 0 && !stop_r && !(sleep && !dbg),
                  croot != 0, aroot != 0};
      e_ahb = croot != 0 ? ahb_mask : 4'h0;
      e_apb = aroot != 0 ? apb_mask : 8'h00;
      e_on = e_on && bus_en;
      e_mbc = aroot != 0 && e_on;
      e_irq = ev;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  always @(negedge ref_clk) begin
    if (!rst) begin
      chk("ticks", 32'(e_ticks), 32'(ticks));
      chk("cpu", 32'(e_ticks.cpu_tick), 32'(ticks.cpu_tick));
      chk("ahb_tick", 32'(e_ahb), 32'(ahb_tick));
      chk("apb_tick", 32'(e_apb), 32'(apb_tick));
      chk("bus_on", 32'(e_on), 32'(on));
      chk("irq", 32'(e_irq), 32'(irq));
      chk("bus_clk", 32'(e_mbc), 32'(mbc));
    end
  end

  task automatic test_done();
    if (failures == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      test_done();
    end
  end

  // Settings change only while the source is stopped; each phase spans a
  // prescaler wrap so a pending setting must wait for it
  initial begin
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    for (int ph = 0; ph < 8; ph++) begin
      run <= 1'b0;
      repeat (12) @(negedge ref_clk);
      if (ph == 5) begin
        rst = 1'b1;
        repeat (10) @(negedge ref_clk);
        rst = 1'b0;
      end
      s = rnd();
      div_cfg = '{cpu_sel: 3'(ph), apb_sel: s[2:0]};
      run <= 1'b1;
      for (int i = 0; i < 2000; i++) begin
        @(negedge ref_clk);
        s = rnd();
        ahb_mask = s[3:0];
        apb_mask = s[11:4];
        stop_r = s[12] & s[13];
        sleep = s[14];
        halt = s[15];
        ev = s[16];
        dbg = s[17];
        // Rare frozen cycles; a phase still spans a prescaler wrap
        ce = !(s[18] & s[19] & s[20] & s[21]);
        bus_en = !(ph == 2 && i == 500);
      end
    end
    test_done();
  end
endmodule : scd_clock_dist_test
